// ### core/cifu_core.sv
// Purpose: Interrupt flags, enables, error flags and mode change of a CAN controller
// Assumes: Protocol engine and serial register engine run on CLK_I
// Notes: Bus activity comes from a pin and is synchronised
//
// Summary of operation
// [RQ1] Receive-full flag sets right after end of frame; interrupt if enabled
// [RQ2] Host clears receive-full flag by writing zero to it
// [RQ3] Any message error sets message-error flag; interrupt only if enabled
// [RQ4] Bus activity in sleep with wake enable sets flag and leaves sleep
// [RQ5] Overflow or error state change sets error flag when enabled
// [RQ6] Accepted message for busy buffer sets its overflow bit; host clears
// [RQ7] Receiver warning when receive error count reaches 96
// [RQ8] Transmitter warning when transmit error count reaches 96
// [RQ9] Receiver error-passive when receive error count exceeds 127
// [RQ10] Transmitter error-passive when transmit error count exceeds 127
// [RQ11] Bus-off when transmit error count passes 255
// [RQ12] Interrupt pending while any enabled flag is set
// [RQ13] Host clear has no effect while the originating condition remains
// [RQ14] Enable register bits: merr, wake, err, tx2..0, rx1..0; reset zero
// [RQ15] Transmit buffer becoming empty sets its flag, interrupt if enabled
// [RQ16] Flag register mirrors enable order; one pending; resets to zero
// [RQ17] Mode changes only after all pending transmissions complete, except a wake from sleep to listen
// [RQ18] Host confirms new mode in status field before further operations
// [RQ19] Interrupt pin low until host clears all pending interrupts
// [RQ20] Interrupt code shows highest-priority enabled source, lower code wins
// [RQ21] Host may set any flag; it interrupts like a hardware set
// [RQ22] Mode codes 0 normal 1 sleep 2 loopback 3 listen 4 config
// [RQ23] Hardware set beats a simultaneous host clear
`timescale 1ns/10ps
module cifu_core
  import cifu_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_WMASK_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Protocol engine events
  input wire logic [1:0] RX_ACCEPT_I,
  input wire logic [2:0] TX_EMPTY_I,
  input wire logic MSG_ERR_I,
  input wire logic TX_PENDING_I,
  input wire logic [8:0] TEC_I,
  input wire logic [8:0] REC_I,
  // Bus pin
  input wire logic BUS_ACTIVITY_I,
  // Outputs
  output logic INT_N_O,
  output logic [2:0] MODE_O,
  output logic [7:0] CTRL_O
);

  logic [7:0] irq_enable_reg;
  logic [7:0] irq_flag_reg;
  logic [1:0] rx_overflow_bit;
  logic [5:0] err_stat;
  logic [5:0] next_err_stat;
  logic [2:0] irq_code_field;
  logic [2:0] mode_request_field;
  logic [7:0] flag_set;
  logic [7:0] flag_hold;
  logic [7:0] pend;
  logic act_s1;
  logic act_s2;
  logic wr_ie;
  logic wr_if;
  logic wr_ef;
  logic wr_ctrl;
  logic wake_evt;
  logic wake_exit;
  logic [7:0] error_flag_reg;
  logic [7:0] ctrl_status_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and bus pin synchroniser

  always_comb begin
    wr_ie = 1'b0;
    wr_if = 1'b0;
    wr_ef = 1'b0;
    wr_ctrl = 1'b0;
    if (REG_WR_I && REG_ADDR_I == ADDR_IRQ_ENABLE) begin
      wr_ie = 1'b1;
    end else if (REG_WR_I && REG_ADDR_I == ADDR_IRQ_FLAG) begin
      wr_if = 1'b1;
    end else if (REG_WR_I && REG_ADDR_I == ADDR_ERROR_FLAG) begin
      wr_ef = 1'b1;
    end else if (REG_WR_I && REG_ADDR_I[3:0] == ADDR_CTRL_LO) begin
      wr_ctrl = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end else begin
      act_s1 <= BUS_ACTIVITY_I;
      act_s2 <= act_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable register

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_enable_reg <= RST_IRQ_ENABLE; // see RQ14
    end else if (wr_ie) begin
      irq_enable_reg <= (irq_enable_reg & ~REG_WMASK_I) | (REG_WDATA_I & REG_WMASK_I); // see RQ14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error state and error flag register

  always_comb begin
    next_err_stat[EF_RXWARN] = REC_I >= WARN_LIMIT; // see RQ7
    next_err_stat[EF_TXWARN] = TEC_I >= WARN_LIMIT; // see RQ8
    next_err_stat[EF_EWARN] = next_err_stat[EF_RXWARN] | next_err_stat[EF_TXWARN];
    next_err_stat[EF_RXPASS] = REC_I > PASSIVE_LIMIT; // see RQ9
    next_err_stat[EF_TXPASS] = TEC_I > PASSIVE_LIMIT; // see RQ10
    next_err_stat[EF_BUSOFF] = TEC_I > BUSOFF_LIMIT; // see RQ11
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      err_stat <= 6'h00;
    end else begin
      err_stat <= next_err_stat;
    end
  end

  // Overflow when an accepted message finds its buffer still full
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_overflow_bit <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (RX_ACCEPT_I[i] && irq_flag_reg[BIT_RX0 + i]) begin
          rx_overflow_bit[i] <= 1'b1; // see RQ6, RQ23
        end else if (wr_ef && REG_WMASK_I[EF_OVF0 + i] && !REG_WDATA_I[EF_OVF0 + i]) begin
          rx_overflow_bit[i] <= 1'b0; // see RQ6
        end
      end
    end
  end

  assign error_flag_reg = {rx_overflow_bit[1], rx_overflow_bit[0], err_stat};

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  assign wake_evt = (MODE_O == MODE_SLEEP) && irq_enable_reg[BIT_WAKE] && act_s2;
  assign wake_exit = (MODE_O == MODE_SLEEP) && (wake_evt || (wr_if && REG_WMASK_I[BIT_WAKE] &&
    REG_WDATA_I[BIT_WAKE] && irq_enable_reg[BIT_WAKE]));

  always_comb begin
    flag_set = 8'h00;
    flag_hold = 8'h00;
    for (int i = 0; i < 2; i++) begin
      flag_set[BIT_RX0 + i] = RX_ACCEPT_I[i] && !irq_flag_reg[BIT_RX0 + i]; // see RQ1
    end
    for (int i = 0; i < 3; i++) begin
      flag_set[BIT_TX0 + i] = TX_EMPTY_I[i]; // see RQ15
    end
    flag_set[BIT_MERR] = MSG_ERR_I; // see RQ3
    flag_set[BIT_WAKE] = wake_evt; // see RQ4
    flag_set[BIT_ERR] = irq_enable_reg[BIT_ERR] &&
      ((next_err_stat[5:1] != err_stat[5:1]) || (|(RX_ACCEPT_I & irq_flag_reg[BIT_RX1:BIT_RX0]))); // see RQ5
    flag_hold[BIT_ERR] = |rx_overflow_bit; // see RQ13
    flag_hold[BIT_WAKE] = wake_evt; // see RQ13
  end

  generate
    for (genvar g = 0; g < 8; g++) begin : g_flag
      cifu_flag_bit u_flag (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .set_i(flag_set[g]),
        .hold_i(flag_hold[g]),
        .wr_i(wr_if && REG_WMASK_I[g]),
        .wdata_i(REG_WDATA_I[g]),
        .flag_o(irq_flag_reg[g])
      ); // see RQ2, RQ16, RQ21, RQ23
    end
  endgenerate

  assign pend = irq_flag_reg & irq_enable_reg; // see RQ12

  cifu_prio_enc u_prio (
    .pend_i(pend),
    .code_o(irq_code_field)
  ); // see RQ20

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      INT_N_O <= 1'b1;
    end else begin
      INT_N_O <= ~(|pend); // see RQ12, RQ19
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register and mode

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CTRL_O <= RST_CTRL;
    end else if (wake_exit) begin
      // Waking rewrites the request so the mode does not fall back into sleep
      CTRL_O <= {MODE_LISTEN, CTRL_O[4:0]}; // see RQ4
    end else if (wr_ctrl) begin
      CTRL_O <= ((CTRL_O & ~REG_WMASK_I) | (REG_WDATA_I & REG_WMASK_I)) & CTRL_IMPL_MASK;
    end
  end

  assign mode_request_field = CTRL_O[7:5];

  // Wake lands in listen-only; other requests wait for the transmitter to drain
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MODE_O <= MODE_CONFIG;
    end else if (wake_exit) begin
      MODE_O <= MODE_LISTEN; // see RQ4
    end else if (mode_request_field != MODE_O && mode_request_field <= MODE_CONFIG && !TX_PENDING_I) begin
      MODE_O <= mode_request_field; // see RQ17, RQ22
    end
  end

  assign ctrl_status_reg = {MODE_O, 1'b0, irq_code_field, 1'b0}; // see RQ18

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == ADDR_IRQ_ENABLE) begin
        REG_RDATA_O <= irq_enable_reg;
      end else if (REG_ADDR_I == ADDR_IRQ_FLAG) begin
        REG_RDATA_O <= irq_flag_reg;
      end else if (REG_ADDR_I == ADDR_ERROR_FLAG) begin
        REG_RDATA_O <= error_flag_reg;
      end else if (REG_ADDR_I[3:0] == ADDR_CTRL_STATUS_LO) begin
        REG_RDATA_O <= ctrl_status_reg;
      end else if (REG_ADDR_I[3:0] == ADDR_CTRL_LO) begin
        REG_RDATA_O <= CTRL_O;
      end else begin
        REG_RDATA_O <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  a_int_asserts: assert property ((|pend) |=> !INT_N_O) // see RQ12
    else $error("interrupt pin not low with enabled flag pending");
  a_int_releases: assert property (!(|pend) |=> INT_N_O) // see RQ19
    else $error("interrupt pin low with nothing pending");
  a_rx_full_set: assert property (RX_ACCEPT_I[0] && !irq_flag_reg[BIT_RX0] |=> irq_flag_reg[BIT_RX0]) // see RQ1
    else $error("receive buffer 0 flag not set after load");
  a_merr_set: assert property (MSG_ERR_I |=> irq_flag_reg[BIT_MERR] ##1 (!irq_enable_reg[BIT_MERR] || !INT_N_O)) // see RQ3
    else $error("message error flag or interrupt missing");
  a_wake_exit: assert property (wake_evt |=> irq_flag_reg[BIT_WAKE] && MODE_O == MODE_LISTEN) // see RQ4
    else $error("wake up did not set flag and leave sleep");
  a_err_change: assert property (irq_enable_reg[BIT_ERR] && $changed(TEC_I > PASSIVE_LIMIT)
                                 |=> ##1 irq_flag_reg[BIT_ERR]) // see RQ5
    else $error("error flag not set on passive state change");
  a_ovf_set: assert property (RX_ACCEPT_I[1] && irq_flag_reg[BIT_RX1] |=> rx_overflow_bit[1]) // see RQ6
    else $error("overflow bit not set for busy buffer 1");
  a_warn_limit: assert property ((REC_I >= WARN_LIMIT) |=> error_flag_reg[EF_RXWARN] && error_flag_reg[EF_EWARN]) // see RQ7
    else $error("receive warning missing at limit");
  a_busoff: assert property ((TEC_I > BUSOFF_LIMIT) |=> err_stat[EF_BUSOFF] && err_stat[EF_TXPASS]) // see RQ11
    else $error("bus off not reported");
  a_err_hold: assert property (irq_flag_reg[BIT_ERR] && (|rx_overflow_bit) |=> irq_flag_reg[BIT_ERR]) // see RQ13
    else $error("error flag cleared while overflow remains");
  a_set_wins: assert property (MSG_ERR_I && wr_if && REG_WMASK_I[BIT_MERR] |=> irq_flag_reg[BIT_MERR]) // see RQ23
    else $error("host clear beat hardware set");
  a_mode_waits: assert property (TX_PENDING_I && !wake_evt && MODE_O != MODE_SLEEP |=> $stable(MODE_O)) // see RQ17
    else $error("mode changed while transmission pending");
  a_code_prio: assert property (pend[BIT_ERR] |-> irq_code_field == IRQ_CODE_ERR) // see RQ20
    else $error("error source not top priority");
  a_wake_request: assert property (wake_exit |=> CTRL_O[7:5] == MODE_LISTEN) // see RQ4
    else $error("request field not moved to listen on wake");

  c_rx_irq: cover property (RX_ACCEPT_I[0] ##1 !INT_N_O ##[1:20] INT_N_O);
  c_overflow: cover property (RX_ACCEPT_I[0] && irq_flag_reg[BIT_RX0]);
  c_wake: cover property (wake_evt);
  c_mode_switch: cover property (TX_PENDING_I ##1 !TX_PENDING_I ##1 $changed(MODE_O));
  c_host_wake: cover property (wake_exit && !wake_evt);

endmodule // cifu_core

// ### core/cifu_flag_bit.sv
// Purpose: One sticky interrupt flag with host write and hold condition
// Assumes: Set, hold and write are all on CLK_I
// Notes: A hardware set always beats a host clear
`timescale 1ns/10ps
module cifu_flag_bit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Hardware side
  input wire logic set_i,
  input wire logic hold_i,
  // Host side
  input wire logic wr_i,
  input wire logic wdata_i,
  // Flag
  output logic flag_o
);

  logic next_flag;

  always_comb begin
    next_flag = flag_o;
    if (set_i) begin
      next_flag = 1'b1;
    end else if (wr_i && wdata_i) begin
      next_flag = 1'b1;
    end else if (wr_i && !hold_i) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule // cifu_flag_bit

// ### core/cifu_pkg.sv
// Purpose: Shared constants for the CAN interrupt flag unit
// Assumes: Byte-wide register port driven by the serial engine on CLK_I
// Notes: Register offsets are the device's own addresses
package cifu_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2b;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h2c;
  localparam logic [7:0] ADDR_ERROR_FLAG = 8'h2d;
  localparam logic [3:0] ADDR_CTRL_STATUS_LO = 4'he;
  localparam logic [3:0] ADDR_CTRL_LO = 4'hf;

  // Reset values and control write mask
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAG = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'he7;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hf7;

  // Flag and enable bit positions
  localparam int BIT_RX0 = 0;
  localparam int BIT_RX1 = 1;
  localparam int BIT_TX0 = 2;
  localparam int BIT_TX1 = 3;
  localparam int BIT_TX2 = 4;
  localparam int BIT_ERR = 5;
  localparam int BIT_WAKE = 6;
  localparam int BIT_MERR = 7;

  // Error flag register positions
  localparam int EF_EWARN = 0;
  localparam int EF_RXWARN = 1;
  localparam int EF_TXWARN = 2;
  localparam int EF_RXPASS = 3;
  localparam int EF_TXPASS = 4;
  localparam int EF_BUSOFF = 5;
  localparam int EF_OVF0 = 6;
  localparam int EF_OVF1 = 7;

  // Error counter limits
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUSOFF_LIMIT = 9'h0ff;

  // Mode codes, shared by request and status fields
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;

  // Interrupt codes
  localparam logic [2:0] IRQ_CODE_NONE = 3'h0;
  localparam logic [2:0] IRQ_CODE_ERR = 3'h1;
  localparam logic [2:0] IRQ_CODE_WAKE = 3'h2;
  localparam logic [2:0] IRQ_CODE_TX0 = 3'h3;
  localparam logic [2:0] IRQ_CODE_TX1 = 3'h4;
  localparam logic [2:0] IRQ_CODE_TX2 = 3'h5;
  localparam logic [2:0] IRQ_CODE_RX0 = 3'h6;
  localparam logic [2:0] IRQ_CODE_RX1 = 3'h7;

endpackage

// ### core/cifu_prio_enc.sv
// Purpose: Interrupt code of the highest priority pending enabled source
// Assumes: Pending vector already gated by the enables
// Notes: Message error has no code of its own
`timescale 1ns/10ps
module cifu_prio_enc
  import cifu_pkg::*;
(
  // Pending sources
  input wire logic [7:0] pend_i,
  // Code
  output logic [2:0] code_o
);

  always_comb begin
    if (pend_i[BIT_ERR]) begin
      code_o = IRQ_CODE_ERR;
    end else if (pend_i[BIT_WAKE]) begin
      code_o = IRQ_CODE_WAKE;
    end else if (pend_i[BIT_TX0]) begin
      code_o = IRQ_CODE_TX0;
    end else if (pend_i[BIT_TX1]) begin
      code_o = IRQ_CODE_TX1;
    end else if (pend_i[BIT_TX2]) begin
      code_o = IRQ_CODE_TX2;
    end else if (pend_i[BIT_RX0]) begin
      code_o = IRQ_CODE_RX0;
    end else if (pend_i[BIT_RX1]) begin
      code_o = IRQ_CODE_RX1;
    end else begin
      code_o = IRQ_CODE_NONE;
    end
  end

endmodule // cifu_prio_enc

// ### verif/cifu_host_model.sv
// Purpose: Host model that reaches the flag unit through its register port
// Assumes: Requests launch on a rising edge and hold until the sampling edge
// Notes: Released lines show the inverted value, never the last one
`timescale 1ns/10ps
module cifu_host_model
  import cifu_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic [7:0] wmask_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    {wr_o, rd_o, addr_o, wdata_o, wmask_o} = '0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_i);
    {addr_o, wdata_o, wmask_o, wr_o} <= {a, d, m, 1'b1};
    @(posedge clk_i);
    {addr_o, wdata_o, wmask_o, wr_o} <= {~a, ~d, ~m, 1'b0};
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge clk_i);
    {addr_o, rd_o} <= {~a, 1'b0};
    #1;
    d = rdata_i;
  endtask
  task automatic clear_flags(input logic [7:0] m);
    wr_reg(ADDR_IRQ_FLAG, 8'h00, m);
  endtask
  task automatic set_flags(input logic [7:0] m);
    wr_reg(ADDR_IRQ_FLAG, 8'hff, m);
  endtask
  task automatic clear_overflow(input logic [7:0] m);
    wr_reg(ADDR_ERROR_FLAG, 8'h00, m);
  endtask
  // Polls the status field up to 20 times until the requested mode shows
  task automatic wait_mode(input logic [2:0] m, output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      rd_reg({4'h0, ADDR_CTRL_STATUS_LO}, s);
      ok = (s[7:5] === m);
    end
  endtask
endmodule // cifu_host_model

// ### verif/tb.sv
// Purpose: Self-checking bench of the CAN interrupt flag unit
// Assumes: Host model drives the register port, bench drives engine events
// Notes: Expectations come from flag order, code table and counter limits
`timescale 1ns/10ps
module tb;
  import cifu_pkg::*;
  logic clk;
  logic rst;
  logic [7:0] addr, wdata, wmask, rdata, ctrl, rv, eo, en;
  logic wr, rd, merr, txp, act, int_n, ok;
  logic [1:0] rxa;
  logic [2:0] txe, mode;
  logic [8:0] tec, rec;
  int error_cnt = 0;
  int samples_checked = 0;
  int fb[6] = '{0, 1, 2, 3, 4, 7};
  logic [2:0] ic[6] = '{IRQ_CODE_RX0, IRQ_CODE_RX1, IRQ_CODE_TX0, IRQ_CODE_TX1, IRQ_CODE_TX2, IRQ_CODE_NONE};
  int cl[5] = '{2, 3, 4, 0, 1};
  logic [2:0] cd[5] = '{IRQ_CODE_TX0, IRQ_CODE_TX1, IRQ_CODE_TX2, IRQ_CODE_RX0, IRQ_CODE_RX1};
  logic [8:0] tv[9] = '{9'h05f, 9'h060, 9'h060, 9'h07f, 9'h080, 9'h080, 9'h0ff, 9'h100, 9'h000};
  logic [8:0] qv[9] = '{9'h05f, 9'h05f, 9'h060, 9'h07f, 9'h07f, 9'h080, 9'h080, 9'h080, 9'h000};
  logic [2:0] mq[5] = '{MODE_LOOPBACK, MODE_LISTEN, MODE_NORMAL, 3'h5, MODE_SLEEP};
  logic [2:0] me[5] = '{MODE_LOOPBACK, MODE_LISTEN, MODE_NORMAL, MODE_NORMAL, MODE_SLEEP};

  cifu_core u_cifu_core (
    .CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
    .REG_WMASK_I(wmask), .REG_RD_I(rd), .REG_RDATA_O(rdata), .RX_ACCEPT_I(rxa), .TX_EMPTY_I(txe),
    .MSG_ERR_I(merr), .TX_PENDING_I(txp), .TEC_I(tec), .REC_I(rec), .BUS_ACTIVITY_I(act),
    .INT_N_O(int_n), .MODE_O(mode), .CTRL_O(ctrl)
  );
  cifu_host_model u_cifu_host_model (
    .clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .wmask_o(wmask), .rd_o(rd), .rdata_i(rdata)
  );

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    u_cifu_host_model.wr_reg(a, d, m);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e, input string msg);
    u_cifu_host_model.rd_reg(a, rv);
    check(rv, e, msg);
  endtask
  task automatic clr(input logic [7:0] m);
    u_cifu_host_model.clear_flags(m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ev(input logic [5:0] v);
    @(posedge clk);
    {merr, txe, rxa} <= v;
    @(posedge clk);
    {merr, txe, rxa} <= 6'h00;
  endtask
  function automatic logic [7:0] err_flags_exp(input logic [8:0] t, input logic [8:0] q);
    err_flags_exp = {2'b00, t > BUSOFF_LIMIT, t > PASSIVE_LIMIT, q > PASSIVE_LIMIT, t >= WARN_LIMIT, q >= WARN_LIMIT,
      t >= WARN_LIMIT || q >= WARN_LIMIT};
  endfunction

  ////////////////////////////////////////////////////////////
  initial begin
    {rst, merr, txp, act, txe, rxa} = 9'h100;
    {tec, rec} = 18'h00000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    check(int_n, 1'b1, "int idle");
    check(mode, MODE_CONFIG, "reset mode");
    r(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE, "enable reset");
    r(ADDR_IRQ_FLAG, RST_IRQ_FLAG, "flag reset");
    w(ADDR_IRQ_ENABLE, 8'ha5, 8'hff);
    r(ADDR_IRQ_ENABLE, 8'ha5, "enable rw");
    w(8'h30, 8'hff, 8'hff);
    r(8'h30, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      w(ADDR_IRQ_ENABLE, 8'h01 << fb[i], 8'hff);
      ev(6'h01 << i);
      cyc(3);
      check(int_n, 1'b0, "event int");
      r(8'h0e, {MODE_CONFIG, 1'b0, ic[i], 1'b0}, "code");
      clr(8'hff);
      cyc(3);
      check(int_n, 1'b1, "int released");
      w(ADDR_IRQ_ENABLE, 8'h00, 8'hff);
      ev(6'h01 << i);
      cyc(3);
      check(int_n, 1'b1, "masked");
      r(ADDR_IRQ_FLAG, 8'h01 << fb[i], "flag set");
      clr(8'hff);
    end
    $display("test events done");
    w(ADDR_IRQ_ENABLE, 8'hff, 8'hff);
    u_cifu_host_model.set_flags(8'h1f);
    for (int j = 0; j < 5; j++) begin
      cyc(3);
      check(int_n, 1'b0, "int held");
      r(8'h0e, {MODE_CONFIG, 1'b0, cd[j], 1'b0}, "priority");
      clr(8'h01 << cl[j]);
    end
    cyc(3);
    check(int_n, 1'b1, "all cleared");
    r(8'h0e, {MODE_CONFIG, 5'h00}, "no code");
    $display("test priority done");
    w(ADDR_IRQ_ENABLE, 8'h23, 8'hff);
    for (int b = 0; b < 2; b++) begin
      ev(6'h01 << b);
      ev(6'h01 << b);
      cyc(3);
      r(ADDR_ERROR_FLAG, 8'h40 << b, "overflow");
      r(ADDR_IRQ_FLAG, 8'h20 | (8'h01 << b), "error flag");
      clr(8'h20);
      r(ADDR_IRQ_FLAG, 8'h20 | (8'h01 << b), "clear held");
      w(ADDR_ERROR_FLAG, 8'hff, 8'h3f);
      r(ADDR_ERROR_FLAG, 8'h40 << b, "read only");
      u_cifu_host_model.clear_overflow(8'h40 << b);
      clr(8'hff);
      cyc(3);
      r(ADDR_IRQ_FLAG, 8'h00, "cleared");
      check(int_n, 1'b1, "released");
    end
    $display("test overflow done");
    w(ADDR_IRQ_ENABLE, 8'h20, 8'hff);
    eo = 8'h00;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk) {tec, rec} <= {tv[k], qv[k]};
      cyc(4);
      en = err_flags_exp(tv[k], qv[k]);
      r(ADDR_ERROR_FLAG, en, "error state");
      check(rv[2], tv[k] >= WARN_LIMIT, "tx warn");
      check(rv[3], qv[k] > PASSIVE_LIMIT, "rx passive");
      check(rv[4], tv[k] > PASSIVE_LIMIT, "tx passive");
      check(rv[5], tv[k] > BUSOFF_LIMIT, "bus off");
      check(int_n, en[5:1] == eo[5:1], "change int");
      clr(8'h20);
      eo = en;
    end
    $display("test counters done");
    w(ADDR_IRQ_ENABLE, 8'h80, 8'hff);
    ev(6'h20);
    fork
      clr(8'h80);
      ev(6'h20);
    join
    cyc(3);
    r(ADDR_IRQ_FLAG, 8'h80, "set beats clear");
    clr(8'h80);
    $display("test race done");
    @(posedge clk) txp <= 1'b1;
    w(8'h0f, {MODE_NORMAL, 5'h07}, 8'hff);
    cyc(6);
    check(mode, MODE_CONFIG, "pending tx");
    check(ctrl, {MODE_NORMAL, 5'h07}, "request");
    @(posedge clk) txp <= 1'b0;
    cyc(3);
    check(mode, MODE_NORMAL, "switched");
    for (int m = 0; m < 5; m++) begin
      w(8'h0f, {mq[m], 5'h07}, 8'hff);
      cyc(3);
      u_cifu_host_model.wait_mode(me[m], ok);
      check(ok, 1'b1, "confirmed");
      check(mode, me[m], "mode pin");
    end
    w(ADDR_IRQ_ENABLE, 8'h40, 8'hff);
    @(posedge clk) act <= 1'b1;
    cyc(8);
    check(mode, MODE_LISTEN, "woke");
    check(int_n, 1'b0, "wake int");
    check(ctrl[7:5], MODE_LISTEN, "request follows wake");
    @(posedge clk) act <= 1'b0;
    cyc(4);
    clr(8'h40);
    cyc(3);
    check(int_n, 1'b1, "wake cleared");
    w(8'h0f, {MODE_SLEEP, 5'h07}, 8'hff);
    u_cifu_host_model.wait_mode(MODE_SLEEP, ok);
    check(ok, 1'b1, "asleep again");
    u_cifu_host_model.set_flags(8'h40);
    cyc(3);
    check(mode, MODE_LISTEN, "host wake");
    check(int_n, 1'b0, "host wake int");
    r(8'h0f, {MODE_LISTEN, 5'h07}, "wake request");
    clr(8'h40);
    cyc(3);
    check(int_n, 1'b1, "host wake cleared");
    $display("test modes done");
    final_report();
  end
  initial begin
    #200000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // tb
